// file: core/ccpu_top.sv
// Capture/compare/PWM unit with its AXI4-Lite register slave.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "ccpu_consts.svh"
module ccpu_top
	import ccpu_pkg::*;
(
	input wire logic i_ref_clk, // System clock, 100 MHz.
	input wire logic i_rstn, // Asynchronous reset, active low.
	input wire logic [7:0] i_awaddr, // Write address.
	input wire logic i_awvalid, // Write address valid.
	output logic o_awready, // Write address ready.
	input wire logic [31:0] i_wdata, // Write data.
	input wire logic [3:0] i_wstrb, // Write byte strobes.
	input wire logic i_wvalid, // Write data valid.
	output logic o_wready, // Write data ready.
	output logic [1:0] o_bresp, // Write response.
	output logic o_bvalid, // Write response valid.
	input wire logic i_bready, // Write response ready.
	input wire logic [7:0] i_araddr, // Read address.
	input wire logic i_arvalid, // Read address valid.
	output logic o_arready, // Read address ready.
	output logic [31:0] o_rdata, // Read data.
	output logic [1:0] o_rresp, // Read response.
	output logic o_rvalid, // Read data valid.
	input wire logic i_rready, // Read data ready.
	input wire logic i_pin_level, // Level on the shared pin.
	input wire logic [15:0] i_timer1_count_count, // Timer1 count.
	input wire logic i_timer1_count_tick, // Timer1 clock rising edge strobe.
	output logic o_timer1_count_reset, // Request to reset timer1.
	output logic o_special_trig, // Special event trigger pulse.
	input wire logic i_adc_enable, // Converter is enabled.
	output logic o_adc_start, // Start conversion pulse.
	input wire logic [7:0] i_timer2_count_count, // Timer2 count.
	input wire logic [7:0] i_timer2_count_period, // Timer2 period.
	input wire logic i_timer2_count_inc, // Timer2 increment strobe.
	input wire logic [1:0] i_timer2_count_low2, // Extra low timer2 count bits.
	output logic o_timer2_count_clear, // Timer2 clear pulse.
	output logic o_cc_out, // Unit output level for the pin.
	output logic o_cc_drive, // Unit owns the pin data.
	output logic o_event_flag // Sticky event flag level.
);
	logic [7:0] value_low_r;
	logic [7:0] value_high_r;
	logic [5:0] ctrl_r;
	logic flag_r;
	logic cmp_latch_r;
	logic match_d_r;
	logic pend_r;
	logic [7:0] aw_addr_r;
	logic aw_have_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic w_have_r;
	logic [3:0] mode;
	ccpu_class_t cls;
	ccpu_sel_t wsel;
	logic wr_go;
	logic wr_ctrl;
	logic cap_hit;
	logic cmp_match;
	logic match_new;
	logic special;
	logic pwm_level;
	logic pwm_load;
	logic [7:0] pwm_duty_high;

	// Maps a byte address onto a register; the index sits four times lower.
	function automatic ccpu_sel_t reg_sel(input logic [7:0] addr);
		ccpu_sel_t s;
		s = SEL_NONE;
		if (addr[1:0] != 2'b00)
			s = SEL_NONE;
		else if (addr[7:2] == `CCPU_IDX_VALUE_LOW)
			s = SEL_LOW;
		else if (addr[7:2] == `CCPU_IDX_VALUE_HIGH)
			s = SEL_HIGH;
		else if (addr[7:2] == `CCPU_IDX_MODE_CTRL)
			s = SEL_CTRL;
		else if (addr[7:2] == `CCPU_IDX_FLAG)
			s = SEL_FLAG;
		return s;
	endfunction : reg_sel

	// Mode decoding and write strobes.
	assign mode = ctrl_r[3:0];
	assign cls = ccpu_class(mode);
	assign wsel = reg_sel(aw_addr_r);
	assign wr_go = aw_have_r && w_have_r && !o_bvalid;
	assign wr_ctrl = wr_go && (wsel == SEL_CTRL) && w_strb_r[0];
	assign special = (mode == `CCPU_MODE_CMP_SPECIAL);

	// Compare runs continuously; only the first cycle of a match counts as an event.
	assign cmp_match = (cls == CCPU_COMPARE) && ({value_high_r, value_low_r} == i_timer1_count_count);
	assign match_new = cmp_match && !match_d_r;

	// Capture path; a pin driven as output still feeds the edge detector.
	ccpu_capture u_capture
	(
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_pin(i_pin_level),
		.i_mode(mode),
		.o_capture(cap_hit)
	);

	// PWM path; the duty is the low value byte over control bits 5:4.
	ccpu_pwm u_pwm
	(
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_enable(cls == CCPU_PWM),
		.i_duty({value_low_r, ctrl_r[5:4]}),
		.i_timer2_count_count(i_timer2_count_count),
		.i_timer2_count_period(i_timer2_count_period),
		.i_timer2_count_inc(i_timer2_count_inc),
		.i_timer2_count_low2(i_timer2_count_low2),
		.o_level(pwm_level),
		.o_timer2_count_clear(o_timer2_count_clear),
		.o_duty_load(pwm_load),
		.o_duty_high(pwm_duty_high)
	);

	// Write address and data are taken in either order and held until the write is done.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_awready <= 1'b1;
			aw_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
		end
		else if (i_awvalid && o_awready)
		begin
			o_awready <= 1'b0;
			aw_have_r <= 1'b1;
			aw_addr_r <= i_awaddr;
		end
		else if (wr_go)
		begin
			aw_have_r <= 1'b0;
		end
		else if (o_bvalid && i_bready)
		begin
			o_awready <= 1'b1;
		end
	end

	// Write data channel.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_wready <= 1'b1;
			w_have_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end
		else if (i_wvalid && o_wready)
		begin
			o_wready <= 1'b0;
			w_have_r <= 1'b1;
			w_data_r <= i_wdata;
			w_strb_r <= i_wstrb;
		end
		else if (wr_go)
		begin
			w_have_r <= 1'b0;
		end
		else if (o_bvalid && i_bready)
		begin
			o_wready <= 1'b1;
		end
	end

	// Write response follows the register update.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_bvalid <= 1'b0;
			o_bresp <= `CCPU_RESP_OKAY;
		end
		else if (wr_go)
		begin
			o_bvalid <= 1'b1;
			o_bresp <= (wsel == SEL_NONE) ? `CCPU_RESP_SLVERR : `CCPU_RESP_OKAY;
		end
		else if (o_bvalid && i_bready)
		begin
			o_bvalid <= 1'b0;
		end
	end

	// Read channel answers one cycle after the address is taken.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= `CCPU_RESP_OKAY;
		end
		else if (i_arvalid && o_arready)
		begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b1;
			o_rresp <= `CCPU_RESP_OKAY;
			case (reg_sel(i_araddr))
				SEL_LOW: o_rdata <= {24'h00_0000, value_low_r};
				SEL_HIGH: o_rdata <= {24'h00_0000, value_high_r};
				SEL_CTRL: o_rdata <= {26'h000_0000, ctrl_r};
				SEL_FLAG: o_rdata <= {29'h0000_0000, flag_r, 2'b00};
				default:
				begin
					o_rdata <= 32'h0000_0000;
					o_rresp <= `CCPU_RESP_SLVERR;
				end
			endcase
		end
		else if (o_rvalid && i_rready)
		begin
			o_rvalid <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	// Mode and duty low bits; bits 7:6 do not exist and read as zero.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			ctrl_r <= `CCPU_MODE_CTRL_RST;
		else if (wr_ctrl)
			ctrl_r <= w_data_r[5:0];
	end

	// Low value byte: a capture wins over a software write in the same cycle.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			value_low_r <= `CCPU_VALUE_RST;
		else if (cap_hit)
			value_low_r <= i_timer1_count_count[7:0];
		else if (wr_go && (wsel == SEL_LOW) && w_strb_r[0])
			value_low_r <= w_data_r[7:0];
	end

	// High value byte: software may not write it while PWM owns it.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			value_high_r <= `CCPU_VALUE_RST;
		else if (cap_hit)
			value_high_r <= i_timer1_count_count[15:8];
		else if (pwm_load)
			value_high_r <= pwm_duty_high;
		else if (wr_go && (wsel == SEL_HIGH) && w_strb_r[0] && (cls != CCPU_PWM))
			value_high_r <= w_data_r[7:0];
	end

	// Sticky event flag; a new event in the clearing cycle keeps it set.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			flag_r <= 1'b0;
		else if (cap_hit || match_new)
			flag_r <= 1'b1;
		else if (wr_go && (wsel == SEL_FLAG) && w_strb_r[0] && w_data_r[`CCPU_FLAG_BIT])
			flag_r <= 1'b0;
	end

	// Match history for event detection.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			match_d_r <= 1'b0;
		else
			match_d_r <= cmp_match;
	end

	// Compare output latch, separate from the port data latch.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			cmp_latch_r <= 1'b0;
		else if (wr_ctrl && (w_data_r[5:0] == 6'h00))
			cmp_latch_r <= 1'b0;
		else if (cls == CCPU_OFF)
			cmp_latch_r <= 1'b0;
		else if (match_new && (mode == `CCPU_MODE_CMP_SET))
			cmp_latch_r <= 1'b1;
		else if (match_new && (mode == `CCPU_MODE_CMP_CLR))
			cmp_latch_r <= 1'b0;
	end

	// Special event: trigger at once, timer1 reset held for its next clock edge.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			pend_r <= 1'b0;
		else if (!special || !cmp_match)
			pend_r <= 1'b0;
		else if (match_new)
			pend_r <= 1'b1;
		else if (i_timer1_count_tick)
			pend_r <= 1'b0;
	end

	// Trigger strobes to timer1 and the converter.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_special_trig <= 1'b0;
			o_adc_start <= 1'b0;
			o_timer1_count_reset <= 1'b0;
		end
		else
		begin
			o_special_trig <= special && match_new;
			o_adc_start <= special && match_new && i_adc_enable;
			o_timer1_count_reset <= special && cmp_match && (match_new || (pend_r && !i_timer1_count_tick));
		end
	end

	// Pin data and ownership; the soft-interrupt and capture modes leave the pin alone.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_cc_out <= 1'b0;
			o_cc_drive <= 1'b0;
		end
		else
		begin
			o_cc_out <= (cls == CCPU_PWM) ? pwm_level : cmp_latch_r;
			o_cc_drive <= (cls == CCPU_PWM) || (mode == `CCPU_MODE_CMP_SET)
				|| (mode == `CCPU_MODE_CMP_CLR);
		end
	end

	// Flag level toward the interrupt logic.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_event_flag <= 1'b0;
		else
			o_event_flag <= flag_r;
	end
endmodule : ccpu_top

// file: include/ccpu_consts.svh
// Register indices, field positions, mode codes and reset values of the capture/compare/PWM unit.
// Behaviour
// - 0000 turns off and resets; 11xx is PWM.
// - Capture codes select falling, rising, 4th, 16th.
// - 1000 drives high, 1001 drives low, flag set.
// - 1010 sets flag only, pin untouched.
// - 1011 sets flag and triggers timer1 reset.
// - Control bits 5:4 are PWM duty LSBs.
// - Capture copies full 16-bit timer1 count.
// - Every capture sets sticky flag bit 2.
// - New capture overwrites unread captured value.
// - Port write on output pin may capture.
// - Prescaler held zero outside capture operation.
// - Prescaler kept when switching capture prescale settings.
// - Compare value against timer1, act on equality.
// - Zero control write forces output latch low.
// - Trigger at match; timer1 resets next tick.
// - Trigger starts conversion only when converter enabled.
// - Match removed before tick cancels timer1 reset.
// - PWM drives 10-bit duty waveform on pin.
// - Period end: clear timer2, set pin, reload duty; a zero duty leaves the pin low.
// - Clear pin when duty equals extended timer2.
// - Duty above period never clears the pin.
// - High value register read-only in PWM.
`ifndef CCPU_CONSTS_SVH
`define CCPU_CONSTS_SVH
`define CCPU_IDX_FLAG 6'h0C
`define CCPU_IDX_VALUE_LOW 6'h15
`define CCPU_IDX_VALUE_HIGH 6'h16
`define CCPU_IDX_MODE_CTRL 6'h17
`define CCPU_MODE_CTRL_RST 6'h00
`define CCPU_VALUE_RST 8'h00
`define CCPU_FLAG_BIT 2
`define CCPU_MODE_CAP_FALL 4'h4
`define CCPU_MODE_CAP_RISE 4'h5
`define CCPU_MODE_CAP_RISE4 4'h6
`define CCPU_MODE_CAP_RISE16 4'h7
`define CCPU_MODE_CMP_SET 4'h8
`define CCPU_MODE_CMP_CLR 4'h9
`define CCPU_MODE_CMP_SOFT 4'hA
`define CCPU_MODE_CMP_SPECIAL 4'hB
`define CCPU_PRESC4_LAST 2'h3
`define CCPU_PRESC16_LAST 4'hF
`define CCPU_RESP_OKAY 2'b00
`define CCPU_RESP_SLVERR 2'b10
`endif

// file: include/ccpu_pkg.sv
// Types and mode decoding shared by the capture/compare/PWM unit.
package ccpu_pkg;
	typedef enum logic [1:0] {CCPU_OFF, CCPU_CAPTURE, CCPU_COMPARE, CCPU_PWM} ccpu_class_t;
	typedef enum logic [2:0] {SEL_NONE, SEL_LOW, SEL_HIGH, SEL_CTRL, SEL_FLAG} ccpu_sel_t;

	// Sorts a mode code into its operating class; unused codes count as off.
	function automatic ccpu_class_t ccpu_class(input logic [3:0] mode);
		ccpu_class_t c;
		c = CCPU_OFF;
		if (mode[3:2] == 2'b11)
		begin
			c = CCPU_PWM;
		end
		else if (mode[3:2] == 2'b10)
		begin
			c = CCPU_COMPARE;
		end
		else if (mode[3:2] == 2'b01)
		begin
			c = CCPU_CAPTURE;
		end
		return c;
	endfunction : ccpu_class
endpackage : ccpu_pkg

// file: core/ccpu_capture.sv
// Capture edge detector and event prescaler.
`timescale 1ns/100ps
`include "ccpu_consts.svh"
module ccpu_capture
	import ccpu_pkg::*;
(
	input wire logic i_ref_clk, // System clock.
	input wire logic i_rstn, // Asynchronous reset, active low.
	input wire logic i_pin, // Level seen on the shared pin.
	input wire logic [3:0] i_mode, // Mode select field.
	output logic o_capture // One-cycle capture pulse.
);
	logic pin_d_r;
	logic [3:0] presc_r;
	logic rise;
	logic fall;
	logic hit;

	// Edges are found against the previous sample of the pin.
	assign rise = i_pin & ~pin_d_r;
	assign fall = ~i_pin & pin_d_r;

	// Pin history.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			pin_d_r <= 1'b0;
		else
			pin_d_r <= i_pin;
	end

	// The prescaler is kept across capture settings but held at zero elsewhere.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			presc_r <= 4'h0;
		else if (ccpu_class(i_mode) != CCPU_CAPTURE)
			presc_r <= 4'h0;
		else if (rise)
			presc_r <= presc_r + 4'h1;
	end

	// Selects the event that makes a capture.
	always_comb
	begin
		case (i_mode)
			`CCPU_MODE_CAP_FALL: hit = fall;
			`CCPU_MODE_CAP_RISE: hit = rise;
			`CCPU_MODE_CAP_RISE4: hit = rise && (presc_r[1:0] == `CCPU_PRESC4_LAST);
			`CCPU_MODE_CAP_RISE16: hit = rise && (presc_r == `CCPU_PRESC16_LAST);
			default: hit = 1'b0;
		endcase
	end

	// Registered capture pulse.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_capture <= 1'b0;
		else
			o_capture <= hit;
	end
endmodule : ccpu_capture

// file: core/ccpu_pwm.sv
// PWM waveform generator with double-buffered 10-bit duty.
`timescale 1ns/100ps
`include "ccpu_consts.svh"
module ccpu_pwm
	import ccpu_pkg::*;
(
	input wire logic i_ref_clk, // System clock.
	input wire logic i_rstn, // Asynchronous reset, active low.
	input wire logic i_enable, // Unit is in PWM operation.
	input wire logic [9:0] i_duty, // First-stage duty value.
	input wire logic [7:0] i_timer2_count_count, // Timer2 count.
	input wire logic [7:0] i_timer2_count_period, // Timer2 period.
	input wire logic i_timer2_count_inc, // Timer2 increment strobe.
	input wire logic [1:0] i_timer2_count_low2, // Quarter-cycle or prescaler bits.
	output logic o_level, // PWM output latch.
	output logic o_timer2_count_clear, // Timer2 clear pulse.
	output logic o_duty_load, // Second stage reloaded.
	output logic [7:0] o_duty_high // Upper duty byte of second stage.
);
	logic [9:0] duty_buf_r;
	logic period_end;

	assign period_end = i_timer2_count_inc && (i_timer2_count_count == i_timer2_count_period);
	assign o_duty_high = duty_buf_r[9:2];

	// Waveform and second-stage duty; a duty beyond the period never matches.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_level <= 1'b0;
			duty_buf_r <= 10'h000;
		end
		else if (!i_enable)
		begin
			o_level <= 1'b0;
			duty_buf_r <= 10'h000;
		end
		else if (period_end)
		begin
			o_level <= (i_duty != 10'h000);
			duty_buf_r <= i_duty;
		end
		else if ({i_timer2_count_count, i_timer2_count_low2} == duty_buf_r)
		begin
			o_level <= 1'b0;
		end
	end

	// Strobes for timer2 and the high value register.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_timer2_count_clear <= 1'b0;
			o_duty_load <= 1'b0;
		end
		else
		begin
			o_timer2_count_clear <= i_enable && period_end;
			o_duty_load <= i_enable && period_end;
		end
	end
endmodule : ccpu_pwm

// file: dv/ccpu_pin_src.sv
// External source on the shared pin, resolved against the unit's own drive.
`timescale 1ns/100ps
module ccpu_pin_src (
	input wire logic i_level, // Level the outside source applies.
	input wire logic i_drive, // Unit owns the pin data.
	input wire logic i_out, // Unit output latch.
	output logic o_pin_level // Resolved pad level.
);
	// The pad shows the unit's latch while it drives, else the outside source.
	assign o_pin_level = i_drive ? i_out : i_level;
endmodule : ccpu_pin_src

// file: dv/ccpu_sva.sv
// Assertions on the ports of the capture/compare/PWM unit.
`timescale 1ns/100ps
module ccpu_sva (
	input wire logic i_ref_clk, // Clock.
	input wire logic i_rstn, // Reset, active low.
	input wire logic i_wvalid, // Write data valid.
	input wire logic o_awready, // Address ready.
	input wire logic o_wready, // Data ready.
	input wire logic o_bvalid, // Response valid.
	input wire logic i_timer1_count_tick, // Timer1 tick.
	input wire logic o_timer1_count_reset, // Timer1 reset request.
	input wire logic o_special_trig, // Trigger pulse.
	input wire logic o_adc_start, // Conversion start.
	input wire logic o_timer2_count_clear, // Timer2 clear.
	input wire logic o_cc_drive, // Unit owns the pin.
	input wire logic o_event_flag // Event flag.
);
	// All checks run on the rising edge and sleep during reset.
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);
	// A tick that timer1 takes while the reset request stands.
	sequence s_tick;
		o_timer1_count_reset && i_timer1_count_tick;
	endsequence
	// No register write is in flight.
	sequence s_quiet;
		!i_wvalid && !o_bvalid && !$past(o_bvalid);
	endsequence
	flag_hold_a: assert property (o_event_flag ##0 s_quiet |=> o_event_flag)
		else $error("event flag fell with no clear");
	trig_once_a: assert property (o_special_trig |=> !o_special_trig)
		else $error("trigger longer than one cycle");
	trig_reset_a: assert property ($rose(o_special_trig) |-> o_timer1_count_reset)
		else $error("trigger without timer1 reset request");
	trig_flag_a: assert property (o_special_trig |-> ##[1:2] o_event_flag)
		else $error("trigger without event flag");
	adc_trig_a: assert property (o_adc_start |-> o_special_trig)
		else $error("conversion start without trigger");
	tick_free_a: assert property (s_tick |-> ##[1:2] !o_timer1_count_reset)
		else $error("reset request stayed after tick");
	clr_pulse_a: assert property (o_timer2_count_clear |=> !o_timer2_count_clear)
		else $error("timer2 clear longer than one cycle");
	pwm_drive_a: assert property (o_timer2_count_clear |-> o_cc_drive)
		else $error("period end while pin not driven");
	bus_busy_a: assert property (o_bvalid |-> !o_awready && !o_wready)
		else $error("write ready during response");
endmodule : ccpu_sva

// file: dv/test_capture_compare_pwm_unit.sv
// Self-checking bench for the capture/compare/PWM unit.
`timescale 1ns/100ps
`include "ccpu_consts.svh"
module test_capture_compare_pwm_unit;
	localparam logic [7:0] a_flg = {`CCPU_IDX_FLAG, 2'b00};
	localparam logic [7:0] a_lo = {`CCPU_IDX_VALUE_LOW, 2'b00};
	localparam logic [7:0] a_hi = {`CCPU_IDX_VALUE_HIGH, 2'b00};
	localparam logic [7:0] a_ctl = {`CCPU_IDX_MODE_CTRL, 2'b00};
	localparam logic [1:0] r_ok = `CCPU_RESP_OKAY;
	localparam logic [1:0] r_err = `CCPU_RESP_SLVERR;
	logic i_ref_clk, i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic i_pin_level, i_timer1_count_tick, i_adc_enable, i_timer2_count_inc, pin_req;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_timer1_count_reset;
	logic o_special_trig, o_adc_start, o_timer2_count_clear, o_cc_out, o_cc_drive, o_event_flag;
	logic [7:0] i_awaddr, i_araddr, i_timer2_count_count, i_timer2_count_period;
	logic [31:0] i_wdata, o_rdata;
	logic [3:0] i_wstrb;
	logic [1:0] o_bresp, o_rresp, i_timer2_count_low2;
	logic [15:0] i_timer1_count_count;
	int num_errors = 0;
	int n_checks = 0;
	int n_trig = 0;
	int n_adc = 0;
	int n_clr = 0;

	ccpu_top dut (.i_ref_clk, .i_rstn, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
		.i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
		.o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_pin_level, .i_timer1_count_count, .i_timer1_count_tick,
		.o_timer1_count_reset, .o_special_trig, .i_adc_enable, .o_adc_start, .i_timer2_count_count,
		.i_timer2_count_period, .i_timer2_count_inc, .i_timer2_count_low2, .o_timer2_count_clear, .o_cc_out, .o_cc_drive,
		.o_event_flag);
	ccpu_pin_src pin_src (.i_level(pin_req), .i_drive(o_cc_drive), .i_out(o_cc_out),
		.o_pin_level(i_pin_level));

	// Free-running 100 MHz clock.
	initial
	begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	// Counts the one-cycle pulses that the unit issues.
	always @(posedge i_ref_clk)
	begin
		n_trig += int'(o_special_trig === 1'b1);
		n_adc += int'(o_adc_start === 1'b1);
		n_clr += int'(o_timer2_count_clear === 1'b1);
	end

	// Prints the verdict and ends the run.
	task automatic stop_test();
		if (num_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	// Compares a seen value with the expected one.
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	// Writes one register; a lost response ends the run.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		logic got;
		got = 1'b0;
		i_awaddr <= a;
		i_wdata <= {24'h00_0000, d};
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		for (n = 0; n < 40 && !got; n++)
		begin
			@(posedge i_ref_clk);
			if (o_awready === 1'b1)
				i_awvalid <= 1'b0;
			if (o_wready === 1'b1)
				i_wvalid <= 1'b0;
			got = (o_bvalid === 1'b1);
		end
		chk(got, 1'b1);
		if (!got)
			stop_test();
		chk(o_bresp, er);
	endtask : wr

	// Reads one register and compares data and response.
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
		int n;
		logic got;
		got = 1'b0;
		i_araddr <= a;
		i_arvalid <= 1'b1;
		for (n = 0; n < 40 && !got; n++)
		begin
			@(posedge i_ref_clk);
			if (o_arready === 1'b1)
				i_arvalid <= 1'b0;
			got = (o_rvalid === 1'b1);
		end
		chk(got, 1'b1);
		if (!got)
			stop_test();
		chk(o_rdata, {24'h00_0000, e});
		chk(o_rresp, er);
	endtask : rd

	// Sets timer1 and the pin source, then lets a capture settle.
	task automatic pin(input logic lv, input logic [15:0] c);
		i_timer1_count_count <= c;
		pin_req <= lv;
		repeat (6) @(posedge i_ref_clk);
	endtask : pin

	// Presents a timer2 state, with an optional increment strobe.
	task automatic tm2(input logic [7:0] c, input logic [1:0] l, input logic inc);
		i_timer2_count_count <= c;
		i_timer2_count_low2 <= l;
		i_timer2_count_inc <= inc;
		@(posedge i_ref_clk);
		i_timer2_count_inc <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
	endtask : tm2

	// Reset values, unused bits and an unmapped address.
	task automatic t_reset();
		rd(a_ctl, 8'h00, r_ok);
		rd(a_flg, 8'h00, r_ok);
		chk(o_cc_out, 1'b0);
		rd(8'h40, 8'h00, r_err);
		wr(8'h40, 8'hFF, r_err);
		wr(a_ctl, 8'hFF, r_ok);
		rd(a_ctl, 8'h3F, r_ok);
	endtask : t_reset

	// Falling and rising edge capture, with an overwrite while the flag is still set.
	task automatic t_capture();
		wr(a_ctl, 8'h04, r_ok);
		wr(a_flg, 8'h04, r_ok);
		pin(1'b1, 16'h1111);
		chk(o_event_flag, 1'b0);
		pin(1'b0, 16'hA5C3);
		rd(a_lo, 8'hC3, r_ok);
		rd(a_hi, 8'hA5, r_ok);
		rd(a_flg, 8'h04, r_ok);
		pin(1'b1, 16'h1111);
		pin(1'b0, 16'h0102);
		rd(a_lo, 8'h02, r_ok);
		wr(a_ctl, 8'h05, r_ok);
		wr(a_flg, 8'h04, r_ok);
		rd(a_flg, 8'h00, r_ok);
		pin(1'b1, 16'h3344);
		rd(a_lo, 8'h44, r_ok);
		rd(a_hi, 8'h33, r_ok);
	endtask : t_capture

	// Prescaled capture; pre edges are counted under the 4-edge code first.
	task automatic t_presc(input logic [7:0] m, input int n, input int pre);
		int k;
		wr(a_ctl, 8'h00, r_ok);
		wr(a_ctl, 8'h06, r_ok);
		wr(a_flg, 8'h04, r_ok);
		for (k = 1; k <= n; k++)
		begin
			if (k == pre + 1)
				wr(a_ctl, m, r_ok);
			if (k == pre + 1)
				wr(a_flg, 8'h04, r_ok);
			pin(1'b0, 16'h0000);
			pin(1'b1, 16'(k));
			if (k < n)
				chk(o_event_flag, 1'b0);
		end
		chk(o_event_flag, 1'b1);
		rd(a_lo, 8'(n), r_ok);
	endtask : t_presc

	// One-cycle compare match under a given mode code.
	task automatic t_cmp(input logic [7:0] m, input logic eo, input logic ed, input logic ad);
		int bt;
		int ba;
		bt = n_trig;
		ba = n_adc;
		i_adc_enable <= ad;
		i_timer1_count_count <= 16'hFFFF;
		wr(a_lo, 8'h34, r_ok);
		wr(a_hi, 8'h12, r_ok);
		wr(a_ctl, m, r_ok);
		wr(a_flg, 8'h04, r_ok);
		i_timer1_count_count <= 16'h1233;
		repeat (4) @(posedge i_ref_clk);
		chk(o_event_flag, 1'b0);
		i_timer1_count_count <= 16'h1234;
		@(posedge i_ref_clk);
		i_timer1_count_count <= 16'h1235;
		repeat (4) @(posedge i_ref_clk);
		chk(o_event_flag, 1'b1);
		chk(o_cc_out, eo);
		chk(o_cc_drive, ed);
		chk(n_trig - bt, m == 8'h0B);
		chk(n_adc - ba, m == 8'h0B && ad);
	endtask : t_cmp

	// Timer1 reset request released by a tick, then cancelled by a value change.
	task automatic t_tick();
		i_timer1_count_count <= 16'h1234;
		repeat (3) @(posedge i_ref_clk);
		chk(o_timer1_count_reset, 1'b1);
		i_timer1_count_tick <= 1'b1;
		@(posedge i_ref_clk);
		i_timer1_count_tick <= 1'b0;
		i_timer1_count_count <= 16'h0000;
		repeat (3) @(posedge i_ref_clk);
		chk(o_timer1_count_reset, 1'b0);
		i_timer1_count_count <= 16'h1234;
		repeat (3) @(posedge i_ref_clk);
		chk(o_timer1_count_reset, 1'b1);
		wr(a_lo, 8'h35, r_ok);
		repeat (3) @(posedge i_ref_clk);
		chk(o_timer1_count_reset, 0);
	endtask : t_tick

	// PWM reload, duty compare, zero duty, long duty and switch-off.
	task automatic t_pwm();
		int k;
		int b;
		b = n_clr;
		i_timer2_count_period <= 8'h03;
		wr(a_lo, 8'h01, r_ok);
		wr(a_ctl, 8'h2C, r_ok);
		tm2(8'h03, 2'b00, 1'b1);
		chk(o_cc_out, 1'b1);
		chk(n_clr - b, 1'b1);
		rd(a_hi, 8'h01, r_ok);
		wr(a_hi, 8'h55, r_ok);
		rd(a_hi, 8'h01, r_ok);
		tm2(8'h01, 2'b01, 1'b0);
		chk(o_cc_out, 1'b1);
		tm2(8'h01, 2'b10, 1'b0);
		chk(o_cc_out, 1'b0);
		wr(a_ctl, 8'h0C, r_ok);
		wr(a_lo, 8'h00, r_ok);
		tm2(8'h03, 2'b00, 1'b1);
		chk(o_cc_out, 1'b0);
		wr(a_lo, 8'h10, r_ok);
		tm2(8'h03, 2'b00, 1'b1);
		for (k = 0; k < 16; k++)
			tm2(8'(k / 4), 2'(k), 1'b0);
		chk(o_cc_out, 1'b1);
		wr(a_ctl, 8'h00, r_ok);
		repeat (3) @(posedge i_ref_clk);
		chk(o_cc_out, 1'b0);
	endtask : t_pwm

	// Reset for three cycles, then every scenario in turn.
	initial
	begin
		i_rstn = 1'b0;
		{i_awvalid, i_wvalid, i_arvalid, i_timer1_count_tick, i_adc_enable} = 5'h00;
		{i_bready, i_rready, i_timer2_count_inc, pin_req} = 4'hC;
		{i_awaddr, i_araddr, i_timer2_count_count, i_timer2_count_period} = 32'h0000_0000;
		i_wdata = 32'h0000_0000;
		i_wstrb = 4'hF;
		i_timer2_count_low2 = 2'h0;
		i_timer1_count_count = 16'hFFFF;
		repeat (3) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		t_reset();
		t_capture();
		t_presc(8'h06, 4, 0);
		t_presc(8'h07, 16, 0);
		t_presc(8'h07, 16, 2);
		t_cmp(8'h08, 1'b1, 1'b1, 1'b0);
		t_cmp(8'h0A, 1'b1, 1'b0, 1'b0);
		t_cmp(8'h39, 1'b0, 1'b1, 1'b0);
		t_cmp(8'h0B, 1'b0, 1'b0, 1'b1);
		t_cmp(8'h0B, 1'b0, 1'b0, 1'b0);
		t_tick();
		t_pwm();
		stop_test();
	end
endmodule : test_capture_compare_pwm_unit

bind ccpu_top ccpu_sva chk (.i_ref_clk, .i_rstn, .i_wvalid, .o_awready, .o_wready, .o_bvalid,
	.i_timer1_count_tick, .o_timer1_count_reset, .o_special_trig, .o_adc_start, .o_timer2_count_clear, .o_cc_drive,
	.o_event_flag);
